// ---- logic/smsd_core.v ----
// Step-mode sync, peak current, load-angle sampling and fault flags
//
// Notes on behaviour
// R1: New step mode applies on next step edge
// R2: Finer mode snaps to nearest finer grid point
// R3: Coarser mode on shared point keeps zero offset
// R4: Coarser mode off grid keeps constant offset
// R5: Controller lowers resolution on shared points only; the testbench also coarsens off grid, at positions 3 and 44
// R6: Current code change applies at next PWM period
// R7: Sample back-emf at every coil zero crossing
// R8: Transparent bit passes voltage, else held sample
// R9: Gain bit selects divide by two or four
// R10: Sample window and zero current time the hold
// R11: Thermal warning comparator sets warning flag
// R12: Thermal shutdown sets flag, drivers high impedance
// R13: Shutdown flag clears after read below warning
// R14: Overcurrent sets per-transistor flag, drivers off
// R15: Overcurrent latched, drivers off until cleared
// R16: Controller avoids rereading during persistent short
// R17: Full duty over 32 ms sets open flag
// R18: Open coil flags fault, keeps current regulating
// R19: Pump fault flag high while pump is low
// R20: Fault output low when any flag set
// R21: Power-up reset output held low for time
// R22: Status read clears latched flags afterwards
// R23: Flags and fault output update only chip-select high
// R24: Every selected step edge moves translator
// R25: Open-coil timer restarts when duty drops
// R26: Flags with cause present set again after clear
`timescale 1ns/1ps
`include "smsd_defines.vh"
module smsd_core #(
    parameter OPEN_CYC = `SMSD_OPEN_CYC,
    parameter POR_CYC = `SMSD_POR_CYC,
    parameter LA_W = `SMSD_LA_W
) (
    sys_clk,
    rst,
    step_advance_input,
    step_dir,
    step_edge_polarity_bit,
    step_mode,
    translator_pos,
    peak_current_code,
    pwm_period_start,
    applied_current_code,
    pwm_sample_hold_window,
    coil_zero_x,
    coil_zero_y,
    coil_voltage,
    angle_out_transparent_bit,
    angle_out_gain_bit,
    load_angle_output,
    temp_warn_in,
    temp_shutdown_in,
    ovc_x_in,
    ovc_y_in,
    duty_full_x,
    duty_full_y,
    pump_low_in,
    spi_cs_n,
    status_read_done,
    thermal_warn_flag,
    thermal_shutdown_flag,
    x_bridge_overcurrent_flags,
    y_bridge_overcurrent_flags,
    coil_open_flags,
    pump_fault_flag,
    driver_enable,
    fault_out_n_oe,
    power_up_reset_out_n_oe
);
    input wire sys_clk;
    input wire rst;
    input wire step_advance_input;
    input wire step_dir;
    input wire step_edge_polarity_bit;
    input wire [`SMSD_MODE_W-1:0] step_mode;
    output reg [`SMSD_POS_W-1:0] translator_pos;
    input wire [4:0] peak_current_code;
    input wire pwm_period_start;
    output reg [4:0] applied_current_code;
    input wire pwm_sample_hold_window;
    input wire coil_zero_x;
    input wire coil_zero_y;
    input wire [LA_W-1:0] coil_voltage;
    input wire angle_out_transparent_bit;
    input wire angle_out_gain_bit;
    output reg [LA_W-1:0] load_angle_output;
    input wire temp_warn_in;
    input wire temp_shutdown_in;
    input wire [`SMSD_OVC_W-1:0] ovc_x_in;
    input wire [`SMSD_OVC_W-1:0] ovc_y_in;
    input wire duty_full_x;
    input wire duty_full_y;
    input wire pump_low_in;
    input wire spi_cs_n;
    input wire [3:0] status_read_done;
    output reg thermal_warn_flag;
    output reg thermal_shutdown_flag;
    output reg [`SMSD_OVC_W-1:0] x_bridge_overcurrent_flags;
    output reg [`SMSD_OVC_W-1:0] y_bridge_overcurrent_flags;
    output reg [1:0] coil_open_flags;
    output reg pump_fault_flag;
    output reg driver_enable;
    output reg fault_out_n_oe;
    output reg power_up_reset_out_n_oe;

    // Synchronised pin and comparator inputs
    wire [16:0] sync_in;
    wire step_s;
    wire warn_s;
    wire tsd_s;
    wire pump_s;
    wire cs_n_s;
    wire [`SMSD_OVC_W-1:0] ovcx_s;
    wire [`SMSD_OVC_W-1:0] ovcy_s;
    wire [1:0] full_s;
    wire [1:0] zero_s;
    smsd_sync2 #(.W(17)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .din({step_advance_input, temp_warn_in, temp_shutdown_in, pump_low_in, spi_cs_n,
              ovc_x_in, ovc_y_in, duty_full_y, duty_full_x, coil_zero_y, coil_zero_x}),
        .dout(sync_in)
    );
    assign {step_s, warn_s, tsd_s, pump_s, cs_n_s, ovcx_s, ovcy_s, full_s, zero_s} = sync_in;

    // Step edge detection on the synchronised pin
    reg step_d;
    wire step_edge;
    assign step_edge = step_edge_polarity_bit ? (step_s & ~step_d) : (~step_s & step_d);

    // Step mode in force; a reprogrammed mode waits for a step edge
    reg [`SMSD_MODE_W-1:0] mode_act;
    reg [`SMSD_POS_W-1:0] incr;
    reg [`SMSD_POS_W-1:0] grid_mask;
    reg [`SMSD_POS_W-1:0] next_pos;
    reg [`SMSD_POS_W-1:0] snapped;

    // Increment and grid of the newly requested mode
    always @* begin
        incr = 7'h01 << step_mode;
        grid_mask = incr - 7'h01;
        // Full step sits on the 45 degree points, odd multiples of 16
        if (step_mode == `SMSD_MODE_FULL) begin
            incr = 7'h20;
            grid_mask = 7'h1f;
        end
        // Finer mode: round to nearest point of its grid [R2]
        snapped = (translator_pos + (incr >> 1)) & ~grid_mask;
        if (step_mode == `SMSD_MODE_FULL) begin
            snapped = ((translator_pos + 7'h10) & 7'h60) | 7'h10;
        end
        if (step_mode < mode_act) begin
            next_pos = step_dir ? snapped + incr : snapped - incr; // [R2]
        end else begin
            // Coarser or same: step from the current position, offset kept [R3] [R4]
            next_pos = step_dir ? translator_pos + incr : translator_pos - incr;
        end
    end

    // Translator: moves on every edge of the selected polarity, drivers on or off [R24]
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            step_d <= 1'b0;
            mode_act <= 3'h0;
            translator_pos <= 7'h00;
        end else begin
            step_d <= step_s;
            if (step_edge) begin
                mode_act <= step_mode; // [R1]
                translator_pos <= next_pos; // [R1] [R24]
            end
        end
    end

    // Peak current code takes effect at the PWM period start [R6]
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            applied_current_code <= 5'h00;
        end else if (pwm_period_start) begin
            applied_current_code <= peak_current_code; // [R6]
        end
    end

    // Load-angle sampling: zero crossing of either coil opens a sample [R7]
    reg zero_active;
    reg zero_active_d;
    reg [LA_W-1:0] held;
    wire [LA_W-1:0] scaled;
    always @* begin
        zero_active = (zero_s[0] | zero_s[1]) & pwm_sample_hold_window; // [R10]
    end
    // Divide by two or four; software cannot see the transient in hold mode [R9]
    assign scaled = angle_out_gain_bit ? (coil_voltage >> 2) : (coil_voltage >> 1);

    // Track during the zero window, hold its last value after it [R8] [R10]
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            zero_active_d <= 1'b0;
            held <= {LA_W{1'b0}};
            load_angle_output <= {LA_W{1'b0}};
        end else begin
            zero_active_d <= zero_active;
            if (zero_active) begin
                held <= scaled; // [R7] [R10]
            end
            if (angle_out_transparent_bit) begin
                load_angle_output <= scaled; // [R8]
            end else if (zero_active_d & ~zero_active) begin
                load_angle_output <= held; // [R8]
            end
        end
    end

    // Open-coil timers, one per coil [R17] [R25]
    localparam OW = 32;
    wire [1:0] open_hit;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_open
            // Each coil owns its counter and hit bit, so no bit has two drivers
            reg [OW-1:0] run_cnt;
            reg hit;
            always @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    run_cnt <= {OW{1'b0}};
                    hit <= 1'b0;
                end else if (!full_s[gi]) begin
                    // Any drop below full duty restarts the count [R25]
                    run_cnt <= {OW{1'b0}};
                    hit <= 1'b0;
                end else if (run_cnt >= OPEN_CYC[OW-1:0]) begin
                    hit <= 1'b1; // [R17]
                end else begin
                    run_cnt <= run_cnt + 32'h1;
                end
            end
            assign open_hit[gi] = hit;
        end
    endgenerate

    // Status flags: only while chip select is high [R23]; a read clears,
    // but a cause still present sets again, set winning [R22] [R26]
    // A read strobe arrives while the synchronised select is still low,
    // so it waits here until the flags may update again [R22] [R23]
    reg [2:0] clear_pend;
    wire [2:0] clear_now;
    assign clear_now = clear_pend | status_read_done[2:0];
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clear_pend <= 3'h0;
        end else if (cs_n_s) begin
            clear_pend <= 3'h0; // Applied in this cycle
        end else begin
            clear_pend <= clear_now; // Kept while the bus is selected
        end
    end
    wire any_flag;
    assign any_flag = thermal_warn_flag | thermal_shutdown_flag | pump_fault_flag
        | (|x_bridge_overcurrent_flags) | (|y_bridge_overcurrent_flags) | (|coil_open_flags);
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            thermal_warn_flag <= 1'b0;
            thermal_shutdown_flag <= 1'b0;
            x_bridge_overcurrent_flags <= 4'h0;
            y_bridge_overcurrent_flags <= 4'h0;
            coil_open_flags <= 2'h0;
            pump_fault_flag <= 1'b1; // Pump not yet up after power-on [R19]
            fault_out_n_oe <= 1'b1;
        end else if (cs_n_s) begin
            // Register 0: warning, open coils, pump
            if (clear_now[0]) begin
                thermal_warn_flag <= warn_s; // [R22] [R26]
                coil_open_flags <= open_hit; // [R22] [R26]
            end else begin
                thermal_warn_flag <= thermal_warn_flag | warn_s; // [R11]
                coil_open_flags <= coil_open_flags | open_hit; // [R17]
            end
            pump_fault_flag <= pump_s; // [R19]
            // Register 1: x bridge overcurrent
            if (clear_now[1]) begin
                x_bridge_overcurrent_flags <= ovcx_s; // [R15] [R26]
            end else begin
                x_bridge_overcurrent_flags <= x_bridge_overcurrent_flags | ovcx_s; // [R14]
            end
            // Register 2: y bridge overcurrent and shutdown
            if (clear_now[2]) begin
                y_bridge_overcurrent_flags <= ovcy_s; // [R15] [R26]
                thermal_shutdown_flag <= tsd_s | (warn_s & thermal_shutdown_flag); // [R13]
            end else begin
                y_bridge_overcurrent_flags <= y_bridge_overcurrent_flags | ovcy_s; // [R14]
                thermal_shutdown_flag <= thermal_shutdown_flag | tsd_s; // [R12]
            end
            fault_out_n_oe <= any_flag; // [R20]
        end
    end

    // Drivers off on shutdown or latched overcurrent; open coil keeps them on [R18]
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            driver_enable <= 1'b0;
        end else begin
            driver_enable <= ~(thermal_shutdown_flag | tsd_s
                | (|x_bridge_overcurrent_flags) | (|y_bridge_overcurrent_flags)
                | (|ovcx_s) | (|ovcy_s)); // [R12] [R14] [R15] [R18]
        end
    end

    // Power-up reset output held low for a fixed count [R21]
    reg [31:0] por_cnt;
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            por_cnt <= 32'h0;
            power_up_reset_out_n_oe <= 1'b1;
        end else if (por_cnt < POR_CYC[31:0]) begin
            por_cnt <= por_cnt + 32'h1;
        end else begin
            power_up_reset_out_n_oe <= 1'b0; // [R21]
        end
    end
endmodule

// ---- logic/smsd_defines.vh ----
// Constants for the stepper step-mode sync and diagnostics block
`ifndef SMSD_DEFINES_VH
`define SMSD_DEFINES_VH
// Translator position width, 1/32 micro-step units
`define SMSD_POS_W 7
// Step mode codes: 0 = 1/32, 1 = 1/16, 2 = 1/8, 3 = 1/4, 4 = half, 5 = full
`define SMSD_MODE_W 3
`define SMSD_MODE_FULL 3'h5
// Clock rate in kHz
`define SMSD_CLK_KHZ 200000
// Open-coil time in ms and its cycle count (least time)
`define SMSD_OPEN_MS 32
`define SMSD_OPEN_CYC (`SMSD_OPEN_MS * `SMSD_CLK_KHZ)
// Power-up reset hold in us and its cycle count
`define SMSD_POR_US 100
`define SMSD_POR_CYC (`SMSD_POR_US * (`SMSD_CLK_KHZ / 1000))
// Load-angle analog code width
`define SMSD_LA_W 10
// Overcurrent flags per bridge (four transistors)
`define SMSD_OVC_W 4
`endif

// ---- logic/smsd_sync2.v ----
// Two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module smsd_sync2 #(
    parameter W = 1
) (
    sys_clk,
    rst,
    din,
    dout
);
    input wire sys_clk;
    input wire rst;
    input wire [W-1:0] din;
    output reg [W-1:0] dout;
    // First stage, read only by the second stage
    reg [W-1:0] meta;

    // Two flops guard against metastability on asynchronous pins
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// ---- test/smsd_monitor.sv ----
// Assertion checker bound to the step-mode sync and diagnostics core
`timescale 1ns/1ps
module smsd_monitor #(
    parameter OPEN_CYC = 6400000,
    parameter POR_CYC = 20000,
    parameter LA_W = 10
) (
    input wire sys_clk,
    input wire rst,
    input wire step_advance_input,
    input wire step_edge_polarity_bit,
    input wire [6:0] translator_pos,
    input wire [4:0] peak_current_code,
    input wire pwm_period_start,
    input wire [4:0] applied_current_code,
    input wire [LA_W-1:0] coil_voltage,
    input wire angle_out_transparent_bit,
    input wire angle_out_gain_bit,
    input wire [LA_W-1:0] load_angle_output,
    input wire temp_warn_in,
    input wire duty_full_x,
    input wire spi_cs_n,
    input wire [3:0] status_read_done,
    input wire thermal_warn_flag,
    input wire thermal_shutdown_flag,
    input wire [3:0] x_bridge_overcurrent_flags,
    input wire [3:0] y_bridge_overcurrent_flags,
    input wire [1:0] coil_open_flags,
    input wire pump_fault_flag,
    input wire driver_enable,
    input wire fault_out_n_oe,
    input wire power_up_reset_out_n_oe
);
    int pc; // Cycles since reset, stops at the hold time
    int dc; // Length of the present full-duty run on coil x
    wire any_flag = thermal_warn_flag | thermal_shutdown_flag | pump_fault_flag
        | (|x_bridge_overcurrent_flags) | (|y_bridge_overcurrent_flags) | (|coil_open_flags);
    // Helper counters; the run counter restarts on every drop of full duty
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pc <= 0;
            dc <= 0;
        end else begin
            pc <= (pc < POR_CYC) ? pc + 1 : pc;
            dc <= duty_full_x ? dc + 1 : 0;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Pin edge of the selected polarity
    sequence s_step_edge;
        step_edge_polarity_bit ? $rose(step_advance_input) : $fell(step_advance_input);
    endsequence
    // Warning seen long enough with the bus deselected
    sequence s_warn_seen;
        (temp_warn_in && spi_cs_n) [*5];
    endsequence
    a_step_moves_pos: assert property (s_step_edge |-> ##[1:5] $changed(translator_pos))
        else $error("step edge did not move position");
    a_cur_at_period: assert property (pwm_period_start |=>
        applied_current_code == $past(peak_current_code)) else $error("current code late");
    a_la_transparent: assert property ($past(angle_out_transparent_bit) && !$past(rst) |->
        load_angle_output == ($past(angle_out_gain_bit) ? $past(coil_voltage) >> 2
        : $past(coil_voltage) >> 1)) else $error("transparent angle output wrong");
    a_warn_sets_flag: assert property (s_warn_seen |=> thermal_warn_flag)
        else $error("warning flag missing");
    a_shut_drv_off: assert property (thermal_shutdown_flag |=> !driver_enable)
        else $error("drivers on in shutdown");
    a_ovc_drv_off: assert property (|x_bridge_overcurrent_flags |=> !driver_enable)
        else $error("drivers on with overcurrent");
    a_ovc_latched: assert property ((!status_read_done[1]) [*4] ##0 (|x_bridge_overcurrent_flags)
        |=> |x_bridge_overcurrent_flags) else $error("overcurrent flag lost");
    a_open_after_run: assert property ($rose(coil_open_flags[0]) |->
        $past(dc, 3) >= OPEN_CYC - 3) else $error("open flag too early");
    // The output only follows while the synchronised select is high
    a_fault_follows: assert property ($past(spi_cs_n, 3) |->
        fault_out_n_oe == $past(any_flag)) else $error("fault output wrong");
    a_por_held: assert property (pc < POR_CYC - 1 |-> power_up_reset_out_n_oe)
        else $error("reset output released early");
endmodule
bind smsd_core smsd_monitor #(.OPEN_CYC(OPEN_CYC), .POR_CYC(POR_CYC), .LA_W(LA_W)) mon (.*);

// ---- test/smsd_mcu_model.sv ----
// Controller model: step pin, chip select and status read strobes
`timescale 1ns/1ps
module smsd_mcu_model (
    input wire sys_clk,
    output logic step_advance_input,
    output logic spi_cs_n,
    output logic [3:0] status_read_done
);
    // Idle: pin low, bus deselected so flags keep updating
    initial begin
        step_advance_input = 1'b0;
        spi_cs_n = 1'b1;
        status_read_done = 4'h0;
    end
    // One step; each level lasts three clocks, above the two-clock minimum
    task automatic pulse_step();
        @(posedge sys_clk) step_advance_input <= 1'b1;
        repeat (3) @(posedge sys_clk);
        step_advance_input <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask
    // Status read; select lifts at once so the flags may clear
    task automatic read_status(input int n);
        @(posedge sys_clk) spi_cs_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        spi_cs_n <= 1'b1;
        status_read_done[n] <= 1'b1;
        @(posedge sys_clk) status_read_done[n] <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
endmodule

// ---- test/tb_stepper_stepmode_sync_and_diag.sv ----
// Testbench for the step-mode sync and diagnostics core
`timescale 1ns/1ps
module tb_stepper_stepmode_sync_and_diag;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] step_mode = 3'h0;
    logic [4:0] peak_current_code = 5'h00;
    logic pwm_period_start = 1'b0;
    logic pwm_sample_hold_window = 1'b0;
    logic coil_zero_x = 1'b0;
    logic [9:0] coil_voltage = 10'h000;
    logic angle_out_transparent_bit = 1'b0;
    logic angle_out_gain_bit = 1'b0;
    logic temp_warn_in = 1'b0;
    logic temp_shutdown_in = 1'b0;
    logic [3:0] ovc_x_in = 4'h0;
    logic duty_full_x = 1'b0;
    logic pump_low_in = 1'b1; // Pump still low at power-up
    logic step_dir = 1'b1;
    logic step_edge_polarity_bit = 1'b1;
    logic coil_zero_y = 1'b0;
    logic duty_full_y = 1'b0;
    logic [3:0] ovc_y_in = 4'h0;
    wire [3:0] y_bridge_overcurrent_flags;
    wire step_advance_input, spi_cs_n;
    wire [3:0] status_read_done, x_bridge_overcurrent_flags;
    wire [6:0] translator_pos;
    wire [4:0] applied_current_code;
    wire [9:0] load_angle_output;
    wire [1:0] coil_open_flags;
    wire thermal_warn_flag, thermal_shutdown_flag, pump_fault_flag;
    wire driver_enable, fault_out_n_oe, power_up_reset_out_n_oe;
    int num_errors = 0;
    int compares = 0;
    // Step modes and positions expected after each step
    int md[9] = '{0, 0, 0, 5, 3, 2, 3, 2, 3};
    int ps[9] = '{1, 2, 3, 35, 40, 44, 52, 56, 64}; // Last coarsening on shared point
    // Short counts keep the run brief; expectations use the same figures
    smsd_core #(.OPEN_CYC(20), .POR_CYC(10)) uut (.*);
    smsd_mcu_model mcu (.*);
    always #2.5 sys_clk = ~sys_clk;
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        if (num_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        wt(20000);
        num_errors++;
        close_out();
    end
    // Main sequence
    initial begin
        wt(9);
        #1 chk("pump_rst", 1, pump_fault_flag);
        wt(1);
        rst <= 1'b0;
        pump_low_in <= 1'b0;
        wt(6);
        #1 chk("por_hold", 1, power_up_reset_out_n_oe);
        mcu.read_status(0);
        #1 chk("por_done", 0, power_up_reset_out_n_oe);
        chk("pump", 0, pump_fault_flag);
        chk("fault_idle", 0, fault_out_n_oe);
        wt(1);
        peak_current_code <= 5'h13;
        wt(3);
        #1 chk("cur_wait", 0, applied_current_code);
        wt(1);
        pwm_period_start <= 1'b1;
        wt(1);
        pwm_period_start <= 1'b0;
        #1 chk("cur", 5'h13, applied_current_code);
        for (int i = 0; i < 9; i++) begin
            wt(1);
            step_mode <= 3'(md[i]);
            wt(6);
            #1 chk("pos_wait", (i == 0) ? 0 : ps[i-1], translator_pos);
            mcu.pulse_step();
            #1 chk("pos", ps[i], translator_pos);
        end
        wt(1);
        coil_voltage <= 10'h0c8;
        angle_out_transparent_bit <= 1'b1;
        wt(3);
        #1 chk("la_half", 10'h064, load_angle_output);
        wt(1);
        angle_out_gain_bit <= 1'b1;
        wt(3);
        #1 chk("la_quarter", 10'h032, load_angle_output);
        wt(1);
        {angle_out_transparent_bit, angle_out_gain_bit} <= 2'b00;
        {coil_zero_x, pwm_sample_hold_window} <= 2'b11;
        coil_voltage <= 10'h100;
        wt(6);
        {coil_zero_x, pwm_sample_hold_window} <= 2'b00;
        wt(5);
        coil_voltage <= 10'h3fe;
        wt(5);
        #1 chk("la_held", 10'h080, load_angle_output);
        wt(1);
        duty_full_x <= 1'b1;
        wt(12);
        duty_full_x <= 1'b0;
        wt(2);
        duty_full_x <= 1'b1;
        wt(12);
        #1 chk("open_early", 0, coil_open_flags);
        for (int k = 0; k < 40 && coil_open_flags !== 2'h1; k++) wt(1);
        #1 chk("open", 1, coil_open_flags);
        chk("open_drv", 1, driver_enable);
        chk("open_fault", 1, fault_out_n_oe);
        mcu.read_status(0);
        #1 chk("open_again", 1, coil_open_flags);
        wt(1);
        duty_full_x <= 1'b0;
        wt(4);
        mcu.read_status(0);
        #1 chk("open_clr", 0, coil_open_flags);
        wt(1);
        ovc_x_in <= 4'h4;
        wt(4);
        ovc_x_in <= 4'h0;
        wt(6);
        #1 chk("ovc", 4'h4, x_bridge_overcurrent_flags);
        chk("ovc_drv", 0, driver_enable);
        mcu.read_status(1); // One read only, after the short is gone
        #1 chk("ovc_clr", 0, x_bridge_overcurrent_flags);
        chk("ovc_drv_on", 1, driver_enable);
        wt(1);
        mcu.spi_cs_n <= 1'b0;
        temp_warn_in <= 1'b1;
        wt(6);
        #1 chk("warn_cs_low", 0, thermal_warn_flag);
        wt(1);
        mcu.spi_cs_n <= 1'b1;
        wt(5);
        #1 chk("warn", 1, thermal_warn_flag);
        wt(1);
        temp_shutdown_in <= 1'b1;
        wt(5);
        #1 chk("shut", 1, thermal_shutdown_flag);
        chk("shut_drv", 0, driver_enable);
        wt(1);
        temp_shutdown_in <= 1'b0;
        wt(4);
        mcu.read_status(2);
        #1 chk("shut_warm", 1, thermal_shutdown_flag);
        wt(1);
        temp_warn_in <= 1'b0;
        wt(4);
        mcu.read_status(2);
        mcu.read_status(0);
        #1 chk("shut_clr", 0, thermal_shutdown_flag);
        chk("warn_clr", 0, thermal_warn_flag);
        chk("fault_clr", 0, fault_out_n_oe);
        // Falling-edge polarity, stepping down: the rising edge must not move
        wt(1);
        {step_dir, step_edge_polarity_bit} <= 2'b00;
        mcu.step_advance_input <= 1'b1;
        wt(4);
        #1 chk("pos_rise_ign", 64, translator_pos);
        wt(1);
        mcu.step_advance_input <= 1'b0;
        wt(4);
        #1 chk("pos_fall", 56, translator_pos);
        // Held sample from the y coil at quarter gain
        wt(1);
        angle_out_gain_bit <= 1'b1;
        {coil_zero_y, pwm_sample_hold_window} <= 2'b11;
        coil_voltage <= 10'h300;
        wt(5);
        #1 chk("la_hold_old", 10'h080, load_angle_output);
        wt(1);
        {coil_zero_y, pwm_sample_hold_window} <= 2'b00;
        wt(5);
        #1 chk("la_held_y", 10'h0c0, load_angle_output);
        // Open coil on the y side
        wt(1);
        duty_full_y <= 1'b1;
        for (int k = 0; k < 40 && coil_open_flags !== 2'h2; k++) wt(1);
        #1 chk("open_y", 2'h2, coil_open_flags);
        chk("open_y_fault", 1, fault_out_n_oe);
        wt(1);
        duty_full_y <= 1'b0;
        wt(4);
        mcu.read_status(0);
        #1 chk("open_y_clr", 0, coil_open_flags);
        // Overcurrent on the y bridge: only a read of its own register clears it
        wt(1);
        ovc_y_in <= 4'h9;
        wt(4);
        ovc_y_in <= 4'h0;
        wt(6);
        #1 chk("ovc_y", 4'h9, y_bridge_overcurrent_flags);
        chk("ovc_y_drv", 0, driver_enable);
        mcu.read_status(1);
        #1 chk("ovc_y_kept", 4'h9, y_bridge_overcurrent_flags);
        mcu.read_status(2);
        #1 chk("ovc_y_clr", 0, y_bridge_overcurrent_flags);
        chk("ovc_y_drv_on", 1, driver_enable);
        chk("fault_end", 0, fault_out_n_oe);
        close_out();
    end
endmodule
